// [bench/host_model.sv]
/*
 * Host controller model that configures the readout block over its register port.
 * Assumes the bench calls one task at a time, just after a rising clock edge.
 */
`timescale 1ns/1ps
module host_model (
    input wire logic clk, // System clock.
    output logic [7:0] reg_addr, // Register offset.
    output logic [15:0] reg_wdata, // Write data.
    output logic reg_wr, // Write strobe.
    input wire logic [15:0] reg_rdata // Read data, one cycle after the offset.
);
    // Idle port with the strobe low.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
    end

    // One write; the strobe is held for exactly one sampling edge.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (a == 8'h20) begin
            v = v | 16'h0104;
        end
        if (a == 8'h1E && v[11]) begin
            v[9] = 1'b0;
        end
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~v;
    endtask

    // One read; the data is taken one edge after the offset is set.
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask

    // Read-modify-write so that reserved bits keep their values.
    task automatic rmw(input logic [7:0] a, input logic [15:0] s, input logic [15:0] c);
        logic [15:0] v;
        rd(a, v);
        wr(a, (v & ~c) | s);
    endtask
endmodule // host_model

// [bench/image_readout_mode_and_gain_tb_top.sv]
/*
 * Self-checking bench of the readout block, run with a small geometry.
 * Assumes the host model on the register port and the bench on the trigger pin.
 */
`timescale 1ns/1ps
module image_readout_mode_and_gain_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic trigger_pin = 1'b0;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rv;
    logic reg_wr, frame_active, row_active, pix_valid, flash;
    logic [11:0] row_addr, col_addr;
    logic [1:0] pix_colour;
    logic [9:0] pix_gain;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int fl, nb, pa, pv, fa;
    // Register cases: offset and data written, offset read, expected data.
    logic [47:0] regs [13] = '{48'h00_0000_0B_0000, 48'h00_0000_1E_8000,
        48'h00_0000_20_1104, 48'h00_0000_2B_0008, 48'h00_0000_2C_0008,
        48'h00_0000_2D_0008, 48'h00_0000_2E_0008, 48'h00_0000_35_0008,
        48'h2B_1234_2B_0034, 48'h35_0051_2E_0051, 48'h2B_0010_35_0010,
        48'h40_FFFF_40_0000, 48'h1E_8004_1E_8004};
    logic [6:0] codes [6] = '{7'h08, 7'h20, 7'h51, 7'h60, 7'h61, 7'h67};
    // Readout modes: two option words, then four expected pixels as row and column.
    logic [63:0] modes [9] = '{64'h8000_1105_00010203, 64'h8004_1105_00041014,
        64'h8010_1105_00102030, 64'h8000_110D_00010405, 64'h8010_1115_00104050,
        64'h8018_1105_00400040, 64'h8030_1105_00000000, 64'h8010_1185_10203040,
        64'h8010_9105_70605040};
    // Frame windows: option words, flash cycles, blanking row-active seen, none in pixels.
    logic [47:0] wins [5] = '{48'h8000_1105_00_0_0, 48'h8200_1105_0A_0_0,
        48'h8600_1105_64_0_0, 48'h8000_1305_00_1_0, 48'h8000_1505_00_1_1};

    always #20 clk = ~clk;

    host_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rdata(reg_rdata));

    readout_ctrl #(.ROWS(8), .COLS(8), .HBLANK(2), .VB_ROWS(10)) i_dut (.clk(clk),
        .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rdata(reg_rdata), .trigger_pin(trigger_pin), .frame_active(frame_active),
        .row_active(row_active), .pix_valid(pix_valid), .row_addr(row_addr),
        .col_addr(col_addr), .pix_colour(pix_colour), .pix_gain(pix_gain), .flash(flash));

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict();
        if (fails == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    // Waits for the end of a shown frame, or for the next valid pixel when v is set.
    task automatic wait_for(input bit v);
        int n;
        logic p;
        n = 0;
        p = 1'b0;
        while ((v ? pix_valid !== 1'b1 : !(p && !frame_active)) && n < 2000) begin
            p = frame_active;
            step(1);
            n++;
        end
        check(16'(n < 2000), 16'h0001);
    endtask

    // Counts flash, row-active and frame cycles over a window, from this sample on.
    task automatic count_win(input int len);
        fl = 0;
        nb = 0;
        pa = 0;
        pv = 0;
        fa = 0;
        repeat (len) begin
            fl += int'(flash === 1'b1);
            nb += int'(row_active === 1'b1 && frame_active === 1'b0);
            pa += int'(row_active === 1'b1 && pix_valid === 1'b1);
            pv += int'(pix_valid === 1'b1);
            fa += int'(frame_active === 1'b1);
            step(1);
        end
    endtask

    // Cycle ceiling that cuts a hang short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        int g;
        logic [7:0] px;
        step(12);
        srst = 1'b0;
        foreach (regs[i]) begin
            i_host.wr(regs[i][47:40], regs[i][39:24]);
            i_host.rd(regs[i][23:16], rv);
            check(rv, regs[i][15:0]);
        end
        i_host.wr(8'h20, 16'h1105);
        foreach (codes[i]) begin
            i_host.wr(8'h35, {9'h000, codes[i]});
            step(4);
            wait_for(1'b1);
            if (codes[i][6] && codes[i][5]) begin
                g = (8 + int'(codes[i][2:0])) * 8;
            end else begin
                g = (int'(codes[i][6]) + 1) * int'(codes[i][5:0]);
            end
            check(16'(pix_gain), 16'(g));
        end
        i_host.wr(8'h2D, 16'h0010);
        i_host.wr(8'h2C, 16'h0018);
        i_host.wr(8'h2E, 16'h0020);
        i_host.wr(8'h2B, 16'h0008);
        foreach (modes[i]) begin
            i_host.wr(8'h1E, modes[i][63:48]);
            i_host.wr(8'h20, modes[i][47:32]);
            wait_for(1'b0);
            wait_for(1'b0);
            for (int k = 3; k >= 0; k--) begin
                wait_for(1'b1);
                px = modes[i][k*8 +: 8];
                check({row_addr[7:0], col_addr[7:0]}, {4'h0, px[7:4], 4'h0, px[3:0]});
                check(16'(pix_gain), 16'(8 * (int'({px[4], px[0]}) + 1)));
                check(16'(pix_colour), 16'({px[4], px[0]}));
                step(1);
            end
        end
        foreach (wins[i]) begin
            i_host.wr(8'h1E, wins[i][47:32]);
            i_host.wr(8'h20, wins[i][31:16]);
            wait_for(1'b0);
            count_win(170);
            check(16'(fl), 16'(wins[i][15:8]));
            check(16'(nb != 0), 16'(wins[i][7:4]));
            check(16'(pa), wins[i][3:0] != 4'h0 ? 16'h0000 : 16'(pv));
        end
        i_host.wr(8'h1E, 16'h8A00);
        step(3);
        check(16'(flash), 16'h0001);
        i_host.wr(8'h1E, 16'h8000);
        step(3);
        check(16'(flash), 16'h0000);
        i_host.wr(8'h20, 16'h1104);
        wait_for(1'b0);
        wait_for(1'b0);
        i_host.wr(8'h1E, 16'h8004);
        count_win(80);
        check(16'(fa), 16'h0000);
        count_win(150);
        check(16'(fa != 0), 16'h0001);
        i_host.wr(8'h20, 16'h1105);
        i_host.rmw(8'h1E, 16'h0100, 16'h0000);
        wait_for(1'b0);
        count_win(300);
        check(16'(fa), 16'h0000);
        trigger_pin = 1'b1;
        step(4);
        trigger_pin = 1'b0;
        count_win(250);
        check(16'(fa != 0), 16'h0001);
        i_host.wr(8'h0B, 16'h0001);
        i_host.rd(8'h0B, rv);
        check(rv, 16'h0000);
        count_win(250);
        check(16'(fa != 0), 16'h0001);
        print_verdict();
    end
endmodule // image_readout_mode_and_gain_tb_top

// [hdl/gain_lookup.sv]
/*
 * Converts a 7-bit gain code to a gain in units of 0.125, registered.
 * Assumes the code is presented one cycle before the pixel it belongs to.
 */
`timescale 1ns/1ps
module gain_lookup (
    input wire logic clk, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    gain_if.rsp gi // Code in, gain out.
);
    logic [9:0] gain_q, gain_d;
    logic [1:0] col_q, col_d;

    // High codes add whole steps above eight; low codes scale the mantissa.
    always_comb begin
        if (gi.code[6] && gi.code[5]) begin
            gain_d = 10'h040 + {4'h0, gi.code[2:0], 3'h0}; // R16
        end else if (gi.code[6]) begin
            gain_d = {3'h0, gi.code[5:0], 1'b0}; // R15
        end else begin
            gain_d = {4'h0, gi.code[5:0]}; // R15
        end
        col_d = gi.colour;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            gain_q <= 10'h008;
            col_q <= 2'h0;
        end else begin
            gain_q <= gain_d;
            col_q <= col_d;
        end
    end

    assign gi.gain = gain_q;
    assign gi.colour_out = col_q;

    a_gain_high: assert property (@(posedge clk) disable iff (srst)
        gi.code[6] && gi.code[5] |=> gain_q == 10'h040 + {4'h0, $past(gi.code[2:0]), 3'h0})
        else $error("High gain code decoded wrongly."); // R16
endmodule // gain_lookup

// [hdl/pin_sync.sv]
/*
 * Two-flop synchroniser for a level from outside the clock domain.
 * Assumes the level is stable for at least two clock periods.
 */
`timescale 1ns/1ps
module pin_sync (
    input wire logic clk, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic pin, // Asynchronous level.
    output logic level // Synchronised level.
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;

    // The second flop alone reads the first one.
    always_comb begin
        meta_d = pin;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign level = sync_q;
endmodule // pin_sync

// [hdl/readout_ctrl.sv]
/*
 * Readout sequencer with skip, flip, mirror, snapshot, flash and per-colour
 * gain registers. Assumes the serial slave presents one register access a
 * cycle on the reg_* port and that the trigger pin is asynchronous.
 */
`timescale 1ns/1ps
module readout_ctrl import readout_pkg::*; #(
    parameter int ROWS = DEF_ROWS,
    parameter int COLS = DEF_COLS,
    parameter int HBLANK = DEF_HBLANK,
    parameter int VB_ROWS = DEF_VB_ROWS
) (
    input wire logic clk, // System clock, 25 MHz.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic [7:0] reg_addr, // Register offset.
    input wire logic [15:0] reg_wdata, // Write data.
    input wire logic reg_wr, // Write strobe, one cycle.
    output logic [15:0] reg_rdata, // Read data of reg_addr, one cycle later.
    input wire logic trigger_pin, // Snapshot trigger, asynchronous.
    output logic frame_active, // Frame-active output.
    output logic row_active, // Row-active output.
    output logic pix_valid, // Pixel shown this cycle.
    output logic [11:0] row_addr, // Physical row of the pixel.
    output logic [11:0] col_addr, // Physical column of the pixel.
    output logic [1:0] pix_colour, // 0 green-one, 1 red, 2 blue, 3 green-two.
    output logic [9:0] pix_gain, // Gain of the pixel in eighths.
    output logic flash // Flash pulse output.
);
    localparam logic [11:0] ROWS_C = 12'(ROWS);
    localparam logic [11:0] COLS_C = 12'(COLS);
    localparam logic [11:0] HB_LAST = 12'(HBLANK - 1);
    localparam logic [11:0] VB_LAST = 12'(VB_ROWS - 1);
    localparam logic [11:0] VB_BOUND = 12'(VB_ROWS - BOUNDARY_ROWS - 1);

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic [15:0] opt_a_q, opt_a_d, opt_b_q, opt_b_d, rdata_q, rdata_d;
    logic [6:0] gain_q [4];
    logic [6:0] gain_d [4];
    logic restart_q, restart_d;
    logic wr_restart;

    // Writes store the value; the restart bit lives for one cycle only.
    always_comb begin
        opt_a_d = opt_a_q;
        opt_b_d = opt_b_q;
        gain_d = gain_q;
        wr_restart = reg_wr && reg_addr == OFS_RESTART && reg_wdata[0];
        restart_d = wr_restart; // R19
        if (reg_wr) begin
            case (reg_addr)
                OFS_OPT_A: opt_a_d = reg_wdata;
                OFS_OPT_B: opt_b_d = reg_wdata;
                OFS_GAIN_G1: gain_d[0] = reg_wdata[6:0]; // R18
                OFS_GAIN_B: gain_d[1] = reg_wdata[6:0];
                OFS_GAIN_R: gain_d[2] = reg_wdata[6:0];
                OFS_GAIN_G2: gain_d[3] = reg_wdata[6:0];
                OFS_GAIN_ALL: begin
                    for (int i = 0; i < 4; i++) begin
                        gain_d[i] = reg_wdata[6:0]; // R21
                    end
                end
                default: ;
            endcase
        end
        case (reg_addr)
            OFS_RESTART: rdata_d = {15'h0000, restart_q};
            OFS_OPT_A: rdata_d = opt_a_q;
            OFS_OPT_B: rdata_d = opt_b_q;
            OFS_GAIN_G1, OFS_GAIN_ALL: rdata_d = {9'h000, gain_q[0]}; // R21
            OFS_GAIN_B: rdata_d = {9'h000, gain_q[1]};
            OFS_GAIN_R: rdata_d = {9'h000, gain_q[2]};
            OFS_GAIN_G2: rdata_d = {9'h000, gain_q[3]};
            default: rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            opt_a_q <= RST_OPT_A; // R01 R02
            opt_b_q <= RST_OPT_B;
            gain_q <= '{RST_GAIN, RST_GAIN, RST_GAIN, RST_GAIN}; // R18
            restart_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            opt_a_q <= opt_a_d;
            opt_b_q <= opt_b_d;
            gain_q <= gain_d;
            restart_q <= restart_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ---------------------------------------------------------------
    // Trigger pin
    // ---------------------------------------------------------------
    logic trig_lvl, trig_old_q, trig_old_d, trig_rise;

    pin_sync u_trig_sync (
        .clk(clk),
        .srst(srst),
        .pin(trigger_pin),
        .level(trig_lvl)
    );

    // A rising edge of the synchronised level counts as one trigger.
    always_comb begin
        trig_old_d = trig_lvl;
        trig_rise = trig_lvl && !trig_old_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            trig_old_q <= 1'b0;
        end else begin
            trig_old_q <= trig_old_d;
        end
    end

    // ---------------------------------------------------------------
    // Frame sequencer
    // ---------------------------------------------------------------
    seq_state_t state_q, state_d;
    logic data_q, data_d; // Data phase of the line.
    logic [11:0] idx_q, idx_d, hb_q, hb_d, row_q, row_d, col_next, row_next;
    logic [15:0] sh_a_q, sh_a_d, sh_b_q, sh_b_d;
    logic bad_q, bad_d, pend_q, pend_d;
    logic line_end, boundary, changed;

    // Lines run in every state so row-active can pulse during blanking.
    always_comb begin
        state_d = state_q;
        data_d = data_q;
        idx_d = idx_q;
        hb_d = hb_q;
        row_d = row_q;
        sh_a_d = sh_a_q;
        sh_b_d = sh_b_q;
        bad_d = bad_q;
        pend_d = pend_q;
        col_next = step_idx(idx_q, sh_a_q[A_COL_SKIP8], sh_a_q[A_COL_SKIP4],
                            sh_b_q[B_COL_2OF4]); // R01 R08
        row_next = step_idx(row_q, sh_a_q[A_ROW_SKIP8], sh_a_q[A_ROW_SKIP4],
                            sh_b_q[B_ROW_2OF4]); // R02 R09
        line_end = !data_q && hb_q == HB_LAST;
        boundary = state_q == ST_VBLANK && line_end && row_q == VB_BOUND; // R20
        changed = sh_a_q[5:2] != opt_a_q[5:2]
            || {sh_b_q[B_ROW_MIRROR], sh_b_q[B_ROW_FLIP], sh_b_q[4:3]}
            != {opt_b_q[B_ROW_MIRROR], opt_b_q[B_ROW_FLIP], opt_b_q[4:3]};
        if (data_q) begin
            idx_d = col_next;
            if (col_next >= COLS_C) begin
                data_d = 1'b0;
                hb_d = 12'h000;
            end
        end else if (line_end) begin
            data_d = 1'b1;
            idx_d = 12'h000;
        end else begin
            hb_d = hb_q + 12'h001;
        end
        if (boundary) begin
            sh_a_d = opt_a_q; // R20
            sh_b_d = opt_b_q;
            bad_d = pend_q || changed; // R07
            pend_d = 1'b0;
        end
        case (state_q)
            ST_WAIT: begin
                if (trig_rise) begin
                    state_d = ST_VBLANK; // R03
                    row_d = 12'h000;
                end
            end
            ST_VBLANK: begin
                if (line_end) begin
                    row_d = row_q + 12'h001;
                    if (row_q == VB_LAST) begin
                        state_d = ST_ACTIVE;
                        row_d = {11'h000, sh_b_q[B_ROW_FLIP]}; // R10
                    end
                end
            end
            ST_ACTIVE: begin
                if (line_end) begin
                    row_d = row_next;
                    if (row_next >= ROWS_C) begin
                        row_d = 12'h000;
                        state_d = opt_a_q[A_SNAPSHOT] ? ST_WAIT : ST_VBLANK; // R03
                    end
                end
            end
            default: state_d = ST_WAIT;
        endcase
        if (restart_q) begin
            state_d = ST_VBLANK; // R19 R03
            row_d = 12'h000;
            data_d = 1'b1;
            idx_d = 12'h000;
            pend_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_VBLANK;
            data_q <= 1'b1;
            idx_q <= 12'h000;
            hb_q <= 12'h000;
            row_q <= 12'h000;
            sh_a_q <= RST_OPT_A;
            sh_b_q <= RST_OPT_B;
            bad_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            state_q <= state_d;
            data_q <= data_d;
            idx_q <= idx_d;
            hb_q <= hb_d;
            row_q <= row_d;
            sh_a_q <= sh_a_d;
            sh_b_q <= sh_b_d;
            bad_q <= bad_d;
            pend_q <= pend_d;
        end
    end

    // ---------------------------------------------------------------
    // Output shaping
    // ---------------------------------------------------------------
    logic fa_q, fa_d, ra_q, ra_d, pv_q, pv_d, fl_q, fl_d, fl_win;
    logic [11:0] raddr_q, raddr_d, caddr_q, caddr_d;
    gain_if gbus ();

    // Frame-active is hidden for a bad frame unless output-all is set; row-active follows its mode.
    always_comb begin
        fa_d = state_q == ST_ACTIVE && (!bad_q || sh_b_q[B_ALL_FRAMES]); // R07
        if (opt_b_q[B_ROW_XOR]) begin
            ra_d = data_q ^ fa_d; // R12
        end else if (opt_b_q[B_CONT_ROW]) begin
            ra_d = data_q; // R11
        end else begin
            ra_d = data_q && fa_d; // R11
        end
        pv_d = data_q && fa_d;
        raddr_d = sh_b_q[B_ROW_MIRROR] ? ROWS_C - 12'h001 - row_q : row_q; // R13
        caddr_d = idx_q;
        fl_win = state_q == ST_VBLANK
            && (opt_a_q[A_FLASH_WIDE] || row_q == VB_LAST); // R05
        fl_d = opt_a_q[A_FLASH_OVR] || (opt_a_q[A_FLASH_EN] && fl_win); // R04 R06
        gbus.colour = {raddr_d[0], caddr_d[0]};
        case (gbus.colour)
            2'h0: gbus.code = gain_q[0];
            2'h1: gbus.code = gain_q[2];
            2'h2: gbus.code = gain_q[1];
            default: gbus.code = gain_q[3];
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fa_q <= 1'b0;
            ra_q <= 1'b0;
            pv_q <= 1'b0;
            fl_q <= 1'b0;
            raddr_q <= 12'h000;
            caddr_q <= 12'h000;
        end else begin
            fa_q <= fa_d;
            ra_q <= ra_d;
            pv_q <= pv_d;
            fl_q <= fl_d;
            raddr_q <= raddr_d;
            caddr_q <= caddr_d;
        end
    end

    gain_lookup u_gain (
        .clk(clk),
        .srst(srst),
        .gi(gbus)
    );

    assign frame_active = fa_q;
    assign row_active = ra_q;
    assign pix_valid = pv_q;
    assign row_addr = raddr_q;
    assign col_addr = caddr_q;
    assign pix_colour = gbus.colour_out;
    assign pix_gain = gbus.gain;
    assign flash = fl_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_restart_self_clear: assert property (wr_restart |=> restart_q ##1 !restart_q
        || $past(wr_restart)) else $error("Restart bit did not clear itself."); // R19
    a_snap_wait_hold: assert property (state_q == ST_WAIT && !trig_rise && !restart_q
        |=> state_q == ST_WAIT) else $error("Snapshot left wait without trigger."); // R03
    a_flash_override: assert property (opt_a_q[A_FLASH_OVR] |=> fl_q)
        else $error("Flash override not driven high."); // R06
    a_flash_off: assert property (!opt_a_q[A_FLASH_EN] && !opt_a_q[A_FLASH_OVR] |=> !fl_q)
        else $error("Flash pulse without enable."); // R04
    a_bad_frame_hide: assert property (bad_q && !sh_b_q[B_ALL_FRAMES] |=> !fa_q)
        else $error("Bad frame was shown."); // R07
    a_vblank_row_quiet: assert property (state_q == ST_VBLANK && opt_b_q[10:9] == 2'h0
        |=> !ra_q) else $error("Row-active pulsed in blanking."); // R11
    a_global_gain: assert property (reg_wr && reg_addr == OFS_GAIN_ALL |=> gain_q[3]
        == $past(reg_wdata[6:0]) && gain_q[1] == gain_q[0])
        else $error("Global gain write missed a colour."); // R21
    a_col_skip8: assert property (pv_q && $past(sh_a_q[A_COL_SKIP8]) |-> caddr_q[2:0] == 3'h0)
        else $error("Column skip by 8 off pattern."); // R01
    a_col_2of4: assert property (pv_q && $past(sh_b_q[B_COL_2OF4])
        && $past(sh_a_q[5:2]) == 4'h0 |-> !caddr_q[1])
        else $error("Column 2-of-4 skip off pattern."); // R08
    a_row_mirror: assert property (pv_q |-> raddr_q == ($past(sh_b_q[B_ROW_MIRROR])
        ? ROWS_C - 12'h001 - $past(row_q) : $past(row_q)))
        else $error("Row address not mirrored as set."); // R13
endmodule // readout_ctrl

// [pkg/gain_if.sv]
/*
 * Carrier between the sequencer and the gain lookup: the code of the pixel
 * about to be shown and its registered gain. Assumes one clock domain.
 */
`timescale 1ns/1ps
interface gain_if;
    logic [6:0] code;
    logic [1:0] colour;
    logic [9:0] gain;
    logic [1:0] colour_out;

    modport req (output code, output colour, input gain, input colour_out);
    modport rsp (input code, input colour, output gain, output colour_out);
endinterface

// [pkg/readout_pkg.sv]
/*
 * Constants, types and shared helpers of the readout-mode and gain block.
 * Assumes a single 25 MHz clock domain and a register port fed by the
 * two-wire serial slave, which lives outside this block.
 */
// How it works
// R01: Column skip-by-4 and skip-by-8 bits step columns by 4 or 8; reset off.
// R02: Row skip-by-4 and skip-by-8 bits step rows by 4 or 8; reset off.
// R03: Snapshot bit holds capture until trigger pin or frame-restart write.
// R04: Flash enable drives flash output while all rows integrate; off by default.
// R05: Width clear gives one row before row-active; set spans whole integration.
// R06: Flash override drives flash output straight to written level.
// R07: First frame after skip or mirror change is suppressed unless output-all set.
// R08: Column 2-of-4 skip outputs two columns then omits two.
// R09: Row 2-of-4 skip outputs two rows then omits two.
// R10: Row flip starts readout one row later.
// R11: Continuous bit keeps row-active pulsing through vertical blanking.
// R12: XOR bit outputs continuous row-active XOR frame-active.
// R13: Row mirror reads rows bottom to top.
// R14: Host keeps bits 2 and 8 of second mode register at one.
// R15: Gain up to eight is (bit6 plus one) times bits 5..0 times 0.125.
// R16: Bits 6 and 5 both set give gain 8 plus bits 2..0.
// R17: Host uses recommended gain code ranges for low, middle, high gains.
// R18: Four 7-bit colour gains, each resetting to unity code.
// R19: Restart bit abandons frame, restarts at first row, then self-clears.
// R20: Skip and mirror changes take effect 8 row times before frame-active.
// R21: Global gain write sets all four gains; read returns green-one gain.
// R22: Host uses read-modify-write so reserved bits keep their defaults.
package readout_pkg;

    // -------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] OFS_RESTART = 8'h0B;
    localparam logic [7:0] OFS_OPT_A = 8'h1E;
    localparam logic [7:0] OFS_OPT_B = 8'h20;
    localparam logic [7:0] OFS_GAIN_G1 = 8'h2B;
    localparam logic [7:0] OFS_GAIN_B = 8'h2C;
    localparam logic [7:0] OFS_GAIN_R = 8'h2D;
    localparam logic [7:0] OFS_GAIN_G2 = 8'h2E;
    localparam logic [7:0] OFS_GAIN_ALL = 8'h35;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [15:0] RST_OPT_A = 16'h8000;
    localparam logic [15:0] RST_OPT_B = 16'h1104;
    localparam logic [6:0] RST_GAIN = 7'h08;

    // -------------------------------------------------------------------
    // Field positions in the first options register
    // -------------------------------------------------------------------
    localparam int A_COL_SKIP4 = 2;
    localparam int A_ROW_SKIP4 = 3;
    localparam int A_COL_SKIP8 = 4;
    localparam int A_ROW_SKIP8 = 5;
    localparam int A_SNAPSHOT = 8;
    localparam int A_FLASH_EN = 9;
    localparam int A_FLASH_WIDE = 10;
    localparam int A_FLASH_OVR = 11;

    // -------------------------------------------------------------------
    // Field positions in the second options register
    // -------------------------------------------------------------------
    localparam int B_ALL_FRAMES = 0;
    localparam int B_COL_2OF4 = 3;
    localparam int B_ROW_2OF4 = 4;
    localparam int B_ROW_FLIP = 7;
    localparam int B_CONT_ROW = 9;
    localparam int B_ROW_XOR = 10;
    localparam int B_ROW_MIRROR = 15;

    // -------------------------------------------------------------------
    // Geometry and timing defaults
    // -------------------------------------------------------------------
    localparam int DEF_ROWS = 1024;
    localparam int DEF_COLS = 1280;
    localparam int DEF_HBLANK = 16;
    localparam int DEF_VB_ROWS = 16;
    localparam int BOUNDARY_ROWS = 8;

    // -------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_VBLANK = 3'b010,
        ST_ACTIVE = 3'b100
    } seq_state_t;

    // Next row or column index for the selected skip pattern.
    function automatic logic [11:0] step_idx(input logic [11:0] idx, input logic s8,
                                             input logic s4, input logic s24);
        logic [11:0] r;
        r = idx + 12'h001;
        if (s8) begin
            r = idx + 12'h008;
        end else if (s4) begin
            r = idx + 12'h004;
        end else if (s24 && idx[0]) begin
            r = idx + 12'h003;
        end
        return r;
    endfunction

endpackage
